// ### shared/sysio_regs.vh
`ifndef SYSIO_REGS_VH
`define SYSIO_REGS_VH
// ============================================================
// I/O port addresses
`define ADDR_DMA_PAGE_UNUSED 8'h80
`define ADDR_DMA_PAGE_CH2    8'h81
`define ADDR_DMA_PAGE_CH3    8'h82
`define ADDR_DMA_PAGE_CH1    8'h83
`define ADDR_NMI_GATE        8'ha0
`define ADDR_KBD_DATA        8'h60
`define ADDR_HW_STATUS       8'h62
`define ADDR_CFG_STATUS      8'hf8
`define ADDR_PWR_DISPLAY     8'hfa
`define ADDR_PWR_COMM        8'hfc
// ============================================================
// Field positions
`define BIT_NMI_GATE         7
`define BIT_LOWBAT_MASK      7
`define BIT_PD_CRT_SEL       0
`define BIT_PD_FD_PWR        1
`define BIT_PD_LCD_PWR       2
`define BIT_PD_BACKLIGHT     3
`define BIT_PD_EXT_KBD       4
`define BIT_PD_VIDEO_DIS     5
`define BIT_PC_SAVE          0
`define BIT_PC_MODEM_PWR     1
`define BIT_PC_MODEM_ROUTE   2
`define BIT_PC_SPK_PWR       3
`define BIT_PC_DIRECT        4
`define BIT_PC_FAST          5
`define BIT_HS_TIMER         5
// ============================================================
// Reset values and masks
`define RST_BYTE             8'h00
`define PD_READ_MASK         8'h0f
// ============================================================
// External keyboard frame
`define EXT_KBD_FRAME_BITS   10
`define EXT_KBD_LAST_COUNT   4'h8
`define EXT_KBD_IDLE_LIMIT   15'h4000
`endif

// ### hw/system_io_control_ports.v
`timescale 1ns/10ps
`include "sysio_regs.vh"
// Notes on behaviour
// - Page registers 81h ch2, 82h ch3, 83h ch1
// - NMI gate bit 7 enables all NMI
// - Reset clears the NMI gate
// - Three NMI sources: coprocessor, two low-battery
// - Port FAh bit 7 masks low-battery one
// - Port FCh bit 7 masks low-battery two
// - F8h bit0 self-test loop, bit1 coprocessor present
// - F8h bits 2-3 encode RAM size
// - F8h bits 4-5 encode initial display type
// - F8h bits 6-7 encode floppy drive count
// - FAh bits 0-3 display select and power
// - FAh bit 4 selects external keyboard
// - FAh bit 5 disables video; bit 6 inert
// - FAh read returns bits 0-3 state
// - FCh bits 0,1,3 power save, modem, speaker
// - FCh bit 2 routing, bit 4 coupling
// - FCh bit 5 fast clock; bit 6 inert
// - Status port bit5 timer, bits 6-7 low
// - IRQ lines 0,1,4,6,7 wired; others free
// - Select internal or external keyboard byte
// - Clock speed pin low for fast mode
module system_io_control_ports (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Host I/O bus
  input  wire [7:0] io_addr,
  input  wire [7:0] io_wdata,
  input  wire       io_wr,
  input  wire       io_rd,
  output reg  [7:0] io_rdata,
  // Straps for the configuration and status ports
  input  wire       strap_loop_post,
  input  wire       strap_copro_present,
  input  wire [1:0] strap_ram_size,
  input  wire [1:0] strap_display,
  input  wire [1:0] strap_fdd_count,
  input  wire [4:0] hw_status_low,
  // NMI sources and output
  input  wire       copro_error,
  input  wire       low_battery1,
  input  wire       low_battery2,
  output reg        nmi,
  // Interrupt sources, timer output and controller inputs
  input  wire       timer_irq,
  input  wire       keyboard_irq,
  input  wire       serial_irq,
  input  wire       floppy_irq,
  input  wire       printer_irq,
  input  wire       timer_out,
  output reg  [7:0] irq_lines,
  // Internal and external keyboard
  input  wire [7:0] int_kbd_data,
  input  wire       key_strobe,
  input  wire       ext_kbd_clk,
  input  wire       ext_kbd_data,
  // DMA page outputs
  output reg  [7:0] dma_page_ch1,
  output reg  [7:0] dma_page_ch2,
  output reg  [7:0] dma_page_ch3,
  // Power, display and communication controls
  output reg        crt_select,
  output reg        floppy_power,
  output reg        lcd_power,
  output reg        panel_backlight,
  output reg        ext_kbd_select,
  output reg        video_disable,
  output reg        power_save,
  output reg        modem_power,
  output reg        modem_route,
  output reg        speaker_power,
  output reg        direct_couple,
  output reg        clock_speed_n
);

  // ============================================================
  // Register state
  reg        nmi_gate_reg;
  reg        lowbat1_en_reg;
  reg        lowbat2_en_reg;
  reg [7:0]  int_kbd_reg;
  reg [7:0]  ext_kbd_reg;
  reg [9:0]  ext_shift_reg;
  reg [3:0]  ext_count_reg;
  reg [14:0] ext_idle_reg;
  reg        ext_clk_prev_reg;

  // Next values of the control outputs and internal state.
  reg [7:0]  rdata_next;
  reg        nmi_next;
  reg [7:0]  irq_next;
  reg [7:0]  dma_page_ch1_next;
  reg [7:0]  dma_page_ch2_next;
  reg [7:0]  dma_page_ch3_next;
  reg        nmi_gate_next;
  reg        lowbat1_en_next;
  reg        lowbat2_en_next;
  reg        crt_select_next;
  reg        floppy_power_next;
  reg        lcd_power_next;
  reg        panel_backlight_next;
  reg        ext_kbd_select_next;
  reg        video_disable_next;
  reg        power_save_next;
  reg        modem_power_next;
  reg        modem_route_next;
  reg        speaker_power_next;
  reg        direct_couple_next;
  reg        clock_speed_n_next;

  reg [7:0]  int_kbd_next;
  reg [7:0]  ext_kbd_next;
  reg [9:0]  ext_shift_next;
  reg [3:0]  ext_count_next;
  reg [14:0] ext_idle_next;

  function wr_hit;
    input [7:0] a;
    begin
      wr_hit = io_wr && (io_addr == a);
    end
  endfunction

  // ============================================================
  // Host writes
  // Every control bit keeps its value unless its own port is written,
  // so a write to one port never disturbs the bits of another.
  always @* begin
    dma_page_ch1_next    = dma_page_ch1;
    dma_page_ch2_next    = dma_page_ch2;
    dma_page_ch3_next    = dma_page_ch3;

    nmi_gate_next        = nmi_gate_reg;
    lowbat1_en_next      = lowbat1_en_reg;
    lowbat2_en_next      = lowbat2_en_reg;

    crt_select_next      = crt_select;
    floppy_power_next    = floppy_power;
    lcd_power_next       = lcd_power;
    panel_backlight_next = panel_backlight;
    ext_kbd_select_next  = ext_kbd_select;
    video_disable_next   = video_disable;

    power_save_next      = power_save;
    modem_power_next     = modem_power;
    modem_route_next     = modem_route;
    speaker_power_next   = speaker_power;
    direct_couple_next   = direct_couple;
    clock_speed_n_next   = clock_speed_n;

    // Port 80h is not decoded at all, so writes there vanish.
    if (wr_hit(`ADDR_DMA_PAGE_CH2)) begin
      dma_page_ch2_next = io_wdata;
    end

    if (wr_hit(`ADDR_DMA_PAGE_CH3)) begin
      dma_page_ch3_next = io_wdata;
    end

    if (wr_hit(`ADDR_DMA_PAGE_CH1)) begin
      dma_page_ch1_next = io_wdata;
    end

    if (wr_hit(`ADDR_NMI_GATE)) begin
      nmi_gate_next = io_wdata[`BIT_NMI_GATE];
    end

    // Bit 6 of both power ports is ignored on purpose.
    if (wr_hit(`ADDR_PWR_DISPLAY)) begin
      crt_select_next      = io_wdata[`BIT_PD_CRT_SEL];
      floppy_power_next    = io_wdata[`BIT_PD_FD_PWR];
      lcd_power_next       = io_wdata[`BIT_PD_LCD_PWR];
      panel_backlight_next = io_wdata[`BIT_PD_BACKLIGHT];
      ext_kbd_select_next  = io_wdata[`BIT_PD_EXT_KBD];
      video_disable_next   = io_wdata[`BIT_PD_VIDEO_DIS];
      lowbat1_en_next      = io_wdata[`BIT_LOWBAT_MASK];
    end

    if (wr_hit(`ADDR_PWR_COMM)) begin
      power_save_next    = io_wdata[`BIT_PC_SAVE];
      modem_power_next   = io_wdata[`BIT_PC_MODEM_PWR];
      modem_route_next   = io_wdata[`BIT_PC_MODEM_ROUTE];
      speaker_power_next = io_wdata[`BIT_PC_SPK_PWR];
      direct_couple_next = io_wdata[`BIT_PC_DIRECT];
      clock_speed_n_next = ~io_wdata[`BIT_PC_FAST];
      lowbat2_en_next    = io_wdata[`BIT_LOWBAT_MASK];
    end
  end

  // The speed pin resets high, so the processor starts at normal speed.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_page_ch1    <= `RST_BYTE;
      dma_page_ch2    <= `RST_BYTE;
      dma_page_ch3    <= `RST_BYTE;

      nmi_gate_reg    <= 1'b0;
      lowbat1_en_reg  <= 1'b0;
      lowbat2_en_reg  <= 1'b0;

      crt_select      <= 1'b0;
      floppy_power    <= 1'b0;
      lcd_power       <= 1'b0;
      panel_backlight <= 1'b0;
      ext_kbd_select  <= 1'b0;
      video_disable   <= 1'b0;

      power_save      <= 1'b0;
      modem_power     <= 1'b0;
      modem_route     <= 1'b0;
      speaker_power   <= 1'b0;
      direct_couple   <= 1'b0;
      clock_speed_n   <= 1'b1;
    end else begin
      dma_page_ch1    <= dma_page_ch1_next;
      dma_page_ch2    <= dma_page_ch2_next;
      dma_page_ch3    <= dma_page_ch3_next;

      nmi_gate_reg    <= nmi_gate_next;
      lowbat1_en_reg  <= lowbat1_en_next;
      lowbat2_en_reg  <= lowbat2_en_next;

      crt_select      <= crt_select_next;
      floppy_power    <= floppy_power_next;
      lcd_power       <= lcd_power_next;
      panel_backlight <= panel_backlight_next;
      ext_kbd_select  <= ext_kbd_select_next;
      video_disable   <= video_disable_next;

      power_save      <= power_save_next;
      modem_power     <= modem_power_next;
      modem_route     <= modem_route_next;
      speaker_power   <= speaker_power_next;
      direct_couple   <= direct_couple_next;
      clock_speed_n   <= clock_speed_n_next;
    end
  end

  // ============================================================
  // NMI combine
  // The NMI is registered so that a glitch on a source cannot pulse the pin.
  always @* begin
    nmi_next = nmi_gate_reg && (copro_error ||
               (low_battery1 && lowbat1_en_reg) ||
               (low_battery2 && lowbat2_en_reg));
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi <= 1'b0;
    end else begin
      nmi <= nmi_next;
    end
  end

  // ============================================================
  // Interrupt request routing; lines 2, 3 and 5 stay low.
  always @* begin
    irq_next = {printer_irq, floppy_irq, 1'b0, serial_irq,
                1'b0, 1'b0, keyboard_irq, timer_irq};
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_lines <= 8'h00;
    end else begin
      irq_lines <= irq_next;
    end
  end

  // ============================================================
  // Keyboard capture
  // The external frame is a start bit then eight data bits, taken on
  // the rising clock edge. The leading ready bit is low and is skipped
  // by waiting for the start bit, which is high.
  // A frame whose clock stalls too long is dropped, so that a keyboard
  // unplugged in mid-frame cannot skew every later byte. The limit is far
  // above any sane half period of the keyboard clock.
  always @* begin
    int_kbd_next   = int_kbd_reg;
    ext_kbd_next   = ext_kbd_reg;
    ext_shift_next = ext_shift_reg;
    ext_count_next = ext_count_reg;
    ext_idle_next  = 15'h0000;

    if (key_strobe) begin
      int_kbd_next = int_kbd_data;
    end

    if ((ext_kbd_clk == ext_clk_prev_reg) && (ext_count_reg != 4'h0)) begin
      ext_idle_next = ext_idle_reg + 15'h0001;
    end

    if (ext_kbd_clk && !ext_clk_prev_reg) begin
      if (ext_count_reg == 4'h0) begin
        if (ext_kbd_data) begin
          ext_count_next = 4'h1;
        end
      end else begin
        ext_shift_next = {ext_kbd_data, ext_shift_reg[9:1]};
        if (ext_count_reg == `EXT_KBD_LAST_COUNT) begin
          ext_kbd_next   = {ext_kbd_data, ext_shift_reg[9:3]};
          ext_count_next = 4'h0;
        end else begin
          ext_count_next = ext_count_reg + 4'h1;
        end
      end
    end else if (ext_idle_reg == `EXT_KBD_IDLE_LIMIT) begin
      ext_count_next = 4'h0;
      ext_idle_next  = 15'h0000;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_kbd_reg      <= 8'h00;
      ext_kbd_reg      <= 8'h00;
      ext_shift_reg    <= 10'h000;
      ext_count_reg    <= 4'h0;
      ext_idle_reg     <= 15'h0000;
      ext_clk_prev_reg <= 1'b1;
    end else begin
      int_kbd_reg      <= int_kbd_next;
      ext_kbd_reg      <= ext_kbd_next;
      ext_shift_reg    <= ext_shift_next;
      ext_count_reg    <= ext_count_next;
      ext_idle_reg     <= ext_idle_next;
      ext_clk_prev_reg <= ext_kbd_clk;
    end
  end

  // ============================================================
  // Host reads
  // Read data is cleared between reads so that a stale byte never lingers.
  always @* begin
    rdata_next = 8'h00;
    case (io_addr)
      `ADDR_CFG_STATUS: begin
        rdata_next = {strap_fdd_count, strap_display, strap_ram_size,
                      strap_copro_present, strap_loop_post};
      end
      `ADDR_PWR_DISPLAY: begin
        rdata_next = {4'h0, panel_backlight, lcd_power,
                      floppy_power, crt_select} & `PD_READ_MASK;
      end
      `ADDR_HW_STATUS: begin
        rdata_next = {2'b00, timer_out, hw_status_low};
      end
      `ADDR_KBD_DATA: begin
        rdata_next = ext_kbd_select ? ext_kbd_reg : int_kbd_reg;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      io_rdata <= rdata_next;
    end else begin
      io_rdata <= 8'h00;
    end
  end

endmodule

// ### bench/sysio_props.sv
`timescale 1ns/10ps
// ============================================================
// Port-level checks of the system I/O control block.
module sysio_props (
  // Clock, reset and host bus
  input wire       clk,
  input wire       rst_n,
  input wire [7:0] io_addr,
  input wire [7:0] io_wdata,
  input wire       io_wr,
  input wire       io_rd,
  input wire [7:0] io_rdata,
  // Watched sources and outputs
  input wire       timer_out,
  input wire       copro_error,
  input wire       low_battery1,
  input wire       low_battery2,
  input wire       nmi,
  input wire [7:0] dma_page_ch2,
  input wire       crt_select,
  input wire       clock_speed_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_nmi_cause: assert property (nmi |-> $past(copro_error | low_battery1 | low_battery2))
    else $error("nmi raised with no source active");
  a_nmi_quiet: assert property (!copro_error && !low_battery1 && !low_battery2 |=> !nmi)
    else $error("nmi raised by something other than the three sources");
  a_reset_nmi: assert property ($rose(rst_n) |-> !nmi)
    else $error("nmi active right after reset");
  a_rdata_idle: assert property (!io_rd |=> io_rdata == 8'h00)
    else $error("read data not zero without a read");
  a_status_high: assert property (io_rd && io_addr == 8'h62 |=> io_rdata[7:5] == {2'b00, $past(timer_out)})
    else $error("status port upper bits wrong");
  a_speed_pin: assert property (io_wr && io_addr == 8'hfc |=> clock_speed_n == !$past(io_wdata[5]))
    else $error("clock speed pin wrong");
  a_page_ch2: assert property (io_wr && io_addr == 8'h81 |=> dma_page_ch2 == $past(io_wdata))
    else $error("channel 2 page not written");
  a_unused_page: assert property (io_wr && io_addr == 8'h80 |=> $stable(dma_page_ch2))
    else $error("write to the unused page address had an effect");
  a_display_sel: assert property (io_wr && io_addr == 8'hfa |=> crt_select == $past(io_wdata[0]))
    else $error("display select not written");
endmodule
bind system_io_control_ports sysio_props u_props (.*);

// ### bench/host_io_model.sv
`timescale 1ns/10ps
// ============================================================
// Host processor side of the I/O bus.
module host_io_model (
  // Clock and answer
  input  wire        clk,
  input  wire  [7:0] io_rdata,
  // Requests
  output logic [7:0] io_addr = 8'h00,
  output logic [7:0] io_wdata = 8'h00,
  output logic       io_wr = 1'b0,
  output logic       io_rd = 1'b0
);
  // Data is inverted on release so a stale value never looks valid.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    io_wdata = ~d;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask
endmodule

// ### bench/system_io_control_ports_tb.sv
`timescale 1ns/10ps
module system_io_control_ports_tb;
  logic       clk = 0, rst_n = 0, timer_out = 0, key_strobe = 0, ext_kbd_clk = 1, ext_kbd_data = 0;
  logic       copro_error = 0, low_battery1 = 0, low_battery2 = 0, strap_loop_post = 0, strap_copro_present = 0;
  logic       timer_irq = 0, keyboard_irq = 0, serial_irq = 0, floppy_irq = 0, printer_irq = 0;
  logic [1:0] strap_ram_size = 0, strap_display = 0, strap_fdd_count = 0;
  logic [4:0] hw_status_low = 0;
  logic [7:0] int_kbd_data = 0, d, r;
  wire  [7:0] io_addr, io_wdata, io_rdata, irq_lines, dma_page_ch1, dma_page_ch2, dma_page_ch3;
  wire        io_wr, io_rd, nmi, crt_select, floppy_power, lcd_power, panel_backlight, ext_kbd_select;
  wire        video_disable, power_save, modem_power, modem_route, speaker_power, direct_couple, clock_speed_n;
  int         error_cnt = 0, n_tests = 0, cyc = 0;
  system_io_control_ports u_system_io_control_ports (.*);
  host_io_model host (.*);
  // ============================================================
  // Clock, timeout and reporting
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function logic [7:0] cfg_exp();
    return {strap_fdd_count, strap_display, strap_ram_size, strap_copro_present, strap_loop_post};
  endfunction
  function logic [7:0] irq_exp();
    return {printer_irq, floppy_irq, 1'b0, serial_irq, 2'b00, keyboard_irq, timer_irq};
  endfunction
  // The serial clock only moves inside a frame; bits change while it is low.
  task ext_send(input logic [7:0] b, input int n);
    logic [9:0] f;
    f = {b, 2'b10};
    for (int k = 0; k < n; k++) begin
      ext_kbd_clk = 0;
      ext_kbd_data = f[k];
      repeat (4) @(negedge clk);
      ext_kbd_clk = 1;
      repeat (4) @(negedge clk);
    end
    ext_kbd_data = 0;
  endtask
  // ============================================================
  // Test sequence
  initial begin
    void'($urandom(58093));
    repeat (5) @(negedge clk);
    rst_n = 1;
    copro_error = 1;
    repeat (2) @(negedge clk);
    chk(nmi, 0);
    host.wr(8'ha0, 8'h80);
    @(negedge clk);
    chk(nmi, 1);
    copro_error = 0;
    low_battery1 = 1;
    repeat (2) @(negedge clk);
    chk(nmi, 0);
    host.wr(8'hfa, 8'h80);
    @(negedge clk);
    chk(nmi, 1);
    low_battery1 = 0;
    low_battery2 = 1;
    repeat (2) @(negedge clk);
    chk(nmi, 0);
    host.wr(8'hfc, 8'h80);
    @(negedge clk);
    chk(nmi, 1);
    host.wr(8'ha0, 8'h7f);
    @(negedge clk);
    chk(nmi, 0);
    low_battery2 = 0;
    for (int i = 0; i < 8; i++) begin
      d = i == 0 ? 8'hff : 8'($urandom);
      host.wr(8'hfa, d);
      chk({video_disable, ext_kbd_select, panel_backlight, lcd_power, floppy_power, crt_select}, d[5:0]);
      host.rd(8'hfa, r);
      chk(r, d & 8'h0f);
      host.wr(8'hfc, d);
      chk({~clock_speed_n, direct_couple, speaker_power, modem_route, modem_power, power_save}, d[5:0]);
      {strap_fdd_count, strap_display, strap_ram_size, strap_copro_present, strap_loop_post} = 8'($urandom);
      host.rd(8'hf8, r);
      chk(r, cfg_exp());
      {timer_out, hw_status_low} = 6'($urandom);
      host.rd(8'h62, r);
      chk(r, {2'b00, timer_out, hw_status_low});
      {printer_irq, floppy_irq, serial_irq, keyboard_irq, timer_irq} = 5'($urandom);
      repeat (2) @(negedge clk);
      chk(irq_lines, irq_exp());
      host.wr(8'h81, d);
      host.wr(8'h82, d + 8'h01);
      host.wr(8'h83, d + 8'h02);
      host.wr(8'h80, ~d);
      chk(dma_page_ch2 ^ dma_page_ch3 ^ dma_page_ch1, d ^ (d + 8'h01) ^ (d + 8'h02));
      chk(dma_page_ch1, d + 8'h02);
      host.rd(8'h55, r);
      chk(r, 8'h00);
    end
    host.wr(8'hfa, 8'h00);
    int_kbd_data = 8'($urandom);
    key_strobe = 1;
    @(negedge clk);
    key_strobe = 0;
    d = int_kbd_data;
    int_kbd_data = ~d;
    host.rd(8'h60, r);
    chk(r, d);
    host.wr(8'hfa, 8'h10);
    d = 8'($urandom);
    ext_send(d, 10);
    host.rd(8'h60, r);
    chk(r, d);
    d = 8'($urandom);
    ext_send(~d, 5);
    repeat (16500) @(negedge clk);
    ext_send(d, 10);
    host.rd(8'h60, r);
    chk(r, d);
    results();
  end
endmodule
